// [hdl/pasl_strap_led.sv]
// What this block does
// - link pin straps address bit 2 after reset release
// - low level gives zero, high gives one
// - link pin lit while link valid
// - tx pin straps bit 3, then output
// - rx pin straps bit 4 after reset release
// - capture a short settle after reset end, then drive led
`timescale 1ns/1ps
`default_nettype none
module pasl_strap_led
	import pasl_pkg::*;
#(
	parameter int SETTLE_CYC = PASL_SETTLE_CYC
)(
	input  wire logic       clk,               // core clock
	input  wire logic       reset,             // async reset, active high
	input  wire logic       linkValid,         // link status
	input  wire logic       txActive,          // transmit activity
	input  wire logic       rxActive,          // receive activity
	input  wire logic       addr2_link_led_pin_i, // pin level in
	input  wire logic       addr3_tx_led_pin_i,   // pin level in
	input  wire logic       addr4_rx_led_pin_i,   // pin level in
	output var  logic       addr2_link_led_pin_o, // pin drive level
	output var  logic       addr3_tx_led_pin_o,   // pin drive level
	output var  logic       addr4_rx_led_pin_o,   // pin drive level
	output var  logic       addr2_link_led_pin_oe_n, // low while driving
	output var  logic       addr3_tx_led_pin_oe_n,   // low while driving
	output var  logic       addr4_rx_led_pin_oe_n,   // low while driving
	output var  logic [2:0] phyAddrHigh,       // address bits 4:2
	output var  logic       addrValid          // strap captured
);
	pasl_phase_t phase;
	logic [7:0]  settleCnt;
	logic        capture;
	logic        drive;
	logic [2:0]  pinIn;
	logic [2:0]  ledState;
	logic [2:0]  addrBits;
	logic [2:0]  pinOut;
	logic [2:0]  pinOe_n;

	assign pinIn    = {addr4_rx_led_pin_i, addr3_tx_led_pin_i, addr2_link_led_pin_i};
	assign ledState = {rxActive, txActive, linkValid};
	assign capture  = (phase == PASL_SETTLE) && (settleCnt == 8'(SETTLE_CYC - 1));
	assign drive    = (phase == PASL_DRIVE);

	// pins stay inputs for a short settle after release, then straps are caught
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			phase     <= PASL_STRAP;
			settleCnt <= 8'h00;
		end else begin
			unique case (phase)
				PASL_STRAP: begin
					phase <= PASL_SETTLE;
				end
				PASL_SETTLE: begin
					if (capture)
						phase <= PASL_DRIVE;
					else
						settleCnt <= settleCnt + 8'h01;
				end
				PASL_DRIVE: begin
					phase <= PASL_DRIVE;
				end
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < PASL_NUM_PINS; g++) begin : gPin
			pasl_pin_cell uCell (
				.clk      (clk),
				.reset    (reset),
				.capture  (capture),
				.drive    (drive),
				.ledState (ledState[g]),
				.pinIn    (pinIn[g]),
				.addrBit  (addrBits[g]),
				.pinOut   (pinOut[g]),
				.pinOe_n  (pinOe_n[g])
			);
		end
	endgenerate

	assign phyAddrHigh             = addrBits;
	assign addr2_link_led_pin_o    = pinOut[PASL_PIN_LINK];
	assign addr3_tx_led_pin_o      = pinOut[PASL_PIN_TX];
	assign addr4_rx_led_pin_o      = pinOut[PASL_PIN_RX];
	assign addr2_link_led_pin_oe_n = pinOe_n[PASL_PIN_LINK];
	assign addr3_tx_led_pin_oe_n   = pinOe_n[PASL_PIN_TX];
	assign addr4_rx_led_pin_oe_n   = pinOe_n[PASL_PIN_RX];

	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			addrValid <= 1'b0;
		else if (capture)
			addrValid <= 1'b1;
	end

	a_strap_oe: assert property (@(posedge clk) disable iff (reset)
		!addrValid |-> (pinOe_n == PASL_OE_INPUT))
		else $error("pin driven before strap capture");
	a_capture_value: assert property (@(posedge clk) disable iff (reset)
		capture |=> (phyAddrHigh == $past(pinIn)))
		else $error("strap value not captured");
	a_link_led: assert property (@(posedge clk) disable iff (reset)
		drive |=> (addr2_link_led_pin_o == $past(linkValid)))
		else $error("link led wrong");
	a_tx_drive: assert property (@(posedge clk) disable iff (reset)
		capture |=> ##1 !addr3_tx_led_pin_oe_n)
		else $error("tx pin not output");
	a_rx_led: assert property (@(posedge clk) disable iff (reset)
		drive |=> (addr4_rx_led_pin_o == $past(rxActive)))
		else $error("rx led wrong");
	a_release_time: assert property (@(posedge clk) disable iff (reset)
		$rose(addrValid) |-> ##1 (pinOe_n == 3'h0))
		else $error("pins not switched to outputs");
	a_addr_hold: assert property (@(posedge clk) disable iff (reset)
		(addrValid && $past(addrValid)) |-> $stable(phyAddrHigh))
		else $error("address changed after capture");
	a_valid_stays: assert property (@(posedge clk) disable iff (reset)
		addrValid |=> addrValid)
		else $error("address valid dropped");

	// cycles since reset release, saturating; used only by the timing checks below
	logic [7:0] sinceRel;
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			sinceRel <= 8'h00;
		else if (sinceRel != 8'hff)
			sinceRel <= sinceRel + 8'h01;
	end

	a_capture_time: assert property (@(posedge clk) disable iff (reset)
		capture
		|-> (sinceRel == 8'(SETTLE_CYC)))
		else $error("strap capture at wrong cycle");

	a_capture_once: assert property (@(posedge clk) disable iff (reset)
		capture
		|=> !capture)
		else $error("second strap capture");

	a_valid_time: assert property (@(posedge clk) disable iff (reset)
		addrValid
		|-> (sinceRel > 8'(SETTLE_CYC)))
		else $error("address valid too early");

	a_input_window: assert property (@(posedge clk) disable iff (reset)
		(sinceRel <= 8'(SETTLE_CYC))
		|-> (pinOe_n == PASL_OE_INPUT))
		else $error("pin driven inside strap window");

	a_quiet_input: assert property (@(posedge clk) disable iff (reset)
		1'b1
		|-> ((pinOut & pinOe_n) == 3'h0))
		else $error("led level shown on input pin");

	a_oe_together: assert property (@(posedge clk) disable iff (reset)
		1'b1
		|-> ((pinOe_n == 3'h0) || (pinOe_n == PASL_OE_INPUT)))
		else $error("pins switched apart");

	a_tx_led: assert property (@(posedge clk) disable iff (reset)
		drive
		|=> (addr3_tx_led_pin_o == $past(txActive)))
		else $error("tx led wrong");

	a_link_oe: assert property (@(posedge clk) disable iff (reset)
		drive
		|=> !addr2_link_led_pin_oe_n)
		else $error("link pin not output");

	a_rx_oe: assert property (@(posedge clk) disable iff (reset)
		drive
		|=> !addr4_rx_led_pin_oe_n)
		else $error("rx pin not output");

	a_link_off: assert property (@(posedge clk) disable iff (reset)
		!drive
		|=> !addr2_link_led_pin_o)
		else $error("link led lit before drive");

	a_bit2_link: assert property (@(posedge clk) disable iff (reset)
		capture
		|=> (phyAddrHigh[0] == $past(addr2_link_led_pin_i)))
		else $error("address bit 2 not from link pin");

	a_bit3_tx: assert property (@(posedge clk) disable iff (reset)
		capture
		|=> (phyAddrHigh[1] == $past(addr3_tx_led_pin_i)))
		else $error("address bit 3 not from tx pin");

	a_bit4_rx: assert property (@(posedge clk) disable iff (reset)
		capture
		|=> (phyAddrHigh[2] == $past(addr4_rx_led_pin_i)))
		else $error("address bit 4 not from rx pin");

	a_addr_zero: assert property (@(posedge clk) disable iff (reset)
		!addrValid
		|-> (phyAddrHigh == PASL_ADDR_RESET))
		else $error("address set before capture");

	a_drive_valid: assert property (@(posedge clk) disable iff (reset)
		drive
		|-> addrValid)
		else $error("drive without captured address");

	a_settle_bound: assert property (@(posedge clk) disable iff (reset)
		1'b1
		|-> (settleCnt < 8'(SETTLE_CYC)))
		else $error("settle counter overran");

	c_tx_on: cover property (@(posedge clk) disable iff (reset) drive && addr3_tx_led_pin_o);
	c_rx_on: cover property (@(posedge clk) disable iff (reset) drive && addr4_rx_led_pin_o);
	c_capture: cover property (@(posedge clk) disable iff (reset) capture);
	c_link_on: cover property (@(posedge clk) disable iff (reset) drive && addr2_link_led_pin_o);
	c_addr_all: cover property (@(posedge clk) disable iff (reset) addrValid && phyAddrHigh == 3'h7);
endmodule : pasl_strap_led
`default_nettype wire

// [hdl/pasl_pkg.sv]
package pasl_pkg;
	localparam int PASL_NUM_PINS = 3;
	localparam int PASL_ADDR_LSB = 2;
	localparam logic [1:0] PASL_ADDR_BITS_W = 2'h3;
	localparam logic [2:0] PASL_ADDR_RESET = 3'h0;
	localparam logic [2:0] PASL_OE_INPUT = 3'h7;
	localparam int PASL_PIN_LINK = 0;
	localparam int PASL_PIN_TX = 1;
	localparam int PASL_PIN_RX = 2;
	localparam int PASL_SETTLE_NS = 8;
	localparam int PASL_CLK_NS = 4;
	localparam int PASL_SETTLE_CYC = (PASL_SETTLE_NS + PASL_CLK_NS - 1) / PASL_CLK_NS;
	typedef enum logic [1:0] {PASL_STRAP, PASL_SETTLE, PASL_DRIVE} pasl_phase_t;
endpackage : pasl_pkg

// [hdl/pasl_pin_cell.sv]
`timescale 1ns/1ps
`default_nettype none
module pasl_pin_cell
	import pasl_pkg::*;
(
	input  wire logic clk,      // core clock
	input  wire logic reset,    // async reset, active high
	input  wire logic capture,  // one-cycle capture strobe
	input  wire logic drive,    // output role active
	input  wire logic ledState, // led status to show
	input  wire logic pinIn,    // pin level
	output var  logic addrBit,  // latched strap bit
	output var  logic pinOut,   // led drive level
	output var  logic pinOe_n   // low while driving
);
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			addrBit <= 1'b0;
		else if (capture)
			addrBit <= pinIn;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pinOut  <= 1'b0;
			pinOe_n <= 1'b1;
		end else begin
			pinOut  <= drive & ledState;
			pinOe_n <= ~drive;
		end
	end
endmodule : pasl_pin_cell
`default_nettype wire

// [tb/pasl_board.sv]
`timescale 1ns/1ps
`default_nettype none
module pasl_board (
	input  wire logic [2:0] strap,  // strap resistor levels
	input  wire logic [2:0] pinOut, // device drive levels
	input  wire logic [2:0] oe_n,   // low while device drives
	output var  logic [2:0] pinLvl, // resolved pin levels
	output var  logic [2:0] ledLit  // led lit as seen on board
);
	// straps only win while the device leaves the pin as an input
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pinLvl[i] = oe_n[i] ? strap[i] : pinOut[i];
			ledLit[i] = !oe_n[i] && pinOut[i];
		end
	end
endmodule : pasl_board
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin errors++; \
	$display("MISMATCH %0t got %h want %h", $time, a, b); end end
module tb_top;
	logic            clk = 0;
	logic            reset = 1;
	logic      [2:0] stat = 0;
	logic      [2:0] strap = 0;
	wire logic [2:0] pinOut, oe_n, pinLvl, ledLit, addr;
	wire logic       addrValid;
	int              errors = 0;
	int              checksDone = 0;
	always #2 clk = ~clk;
	pasl_strap_led dut (.clk(clk), .reset(reset), .linkValid(stat[0]), .txActive(stat[1]),
		.rxActive(stat[2]), .addr2_link_led_pin_i(pinLvl[0]), .addr3_tx_led_pin_i(pinLvl[1]),
		.addr4_rx_led_pin_i(pinLvl[2]), .addr2_link_led_pin_o(pinOut[0]),
		.addr3_tx_led_pin_o(pinOut[1]), .addr4_rx_led_pin_o(pinOut[2]),
		.addr2_link_led_pin_oe_n(oe_n[0]), .addr3_tx_led_pin_oe_n(oe_n[1]),
		.addr4_rx_led_pin_oe_n(oe_n[2]), .phyAddrHigh(addr), .addrValid(addrValid));
	pasl_board board (.strap(strap), .pinOut(pinOut), .oe_n(oe_n), .pinLvl(pinLvl),
		.ledLit(ledLit));
	task automatic do_reset(input logic [2:0] s);
		@(negedge clk);
		reset = 1;
		strap = s;
		repeat (6) @(negedge clk);
		`CHK(oe_n, 3'h7)
		`CHK(addrValid, 1'b0)
		reset = 0;
		for (int i = 0; i < 10 && addrValid !== 1'b1; i++) @(negedge clk);
		`CHK(addr, s)
	endtask : do_reset
	task automatic test_straps;
		for (int s = 0; s < 8; s++) begin
			do_reset(s[2:0]);
			@(negedge clk);
			`CHK(oe_n, 3'h0)
		end
		$display("test_straps done");
	endtask : test_straps
	task automatic test_leds;
		do_reset(3'h5);
		strap = 3'h2;
		for (int p = 0; p < 8; p++) begin
			stat = p[2:0];
			repeat (2) @(negedge clk);
			`CHK(ledLit, p[2:0])
			`CHK(addr, 3'h5)
		end
		$display("test_leds done");
	endtask : test_leds
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : stop_test
	initial begin
		#4000;
		errors++;
		stop_test();
	end
	initial begin
		test_straps();
		test_leds();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
